// *** hdl/pcd_top.sv ***
// APB register block that gates the clocks of the on-chip peripherals
`timescale 1ns/1ps
`include "pcd_params.svh"

module pcd_top #(
	parameter logic [31:0] PRESENT_1 = `PCD_MASK_DIS1,
	parameter logic [31:0] PRESENT_2 = `PCD_MASK_DIS2,
	parameter logic [31:0] PRESENT_3 = `PCD_MASK_DIS3,
	parameter logic [31:0] PRESENT_4 = `PCD_MASK_DIS4,
	parameter logic [31:0] PRESENT_5 = `PCD_MASK_DIS5,
	parameter int          NPERIPH   = `PCD_NUM_PERIPH
) (
	// Clock, reset, clock enable
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  ce,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire pcd_pkg::pcd_addr_t    paddr,
	input  wire pcd_pkg::pcd_word_t    pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output pcd_pkg::pcd_word_t         prdata,
	output logic                       pslverr,
	// Per-peripheral gating
	output logic [NPERIPH-1:0]         periph_disable_bit,
	output logic [NPERIPH-1:0]         periph_gclk,
	// Per-peripheral register access filter
	input  wire logic [NPERIPH-1:0]    periph_pwrite_in,
	output logic [NPERIPH-1:0]         periph_pwrite_out,
	output logic [NPERIPH-1:0]         periph_rvalid
);
	// Absent peripherals have no flag, so they can never be gated by accident
	localparam logic [31:0] WMASK_1 = PRESENT_1 & `PCD_MASK_DIS1;
	localparam logic [31:0] WMASK_2 = PRESENT_2 & `PCD_MASK_DIS2;
	localparam logic [31:0] WMASK_3 = PRESENT_3 & `PCD_MASK_DIS3;
	localparam logic [31:0] WMASK_4 = PRESENT_4 & `PCD_MASK_DIS4;
	localparam logic [31:0] WMASK_5 = PRESENT_5 & `PCD_MASK_DIS5;

	pcd_pkg::pcd_word_t periph_disable_1;
	pcd_pkg::pcd_word_t periph_disable_2;
	pcd_pkg::pcd_word_t periph_disable_3;
	pcd_pkg::pcd_word_t periph_disable_4;
	pcd_pkg::pcd_word_t periph_disable_5;

	// Address decode
	wire                hit_1      = (paddr == `PCD_OFS_DIS1);
	wire                hit_2      = (paddr == `PCD_OFS_DIS2);
	wire                hit_3      = (paddr == `PCD_OFS_DIS3);
	wire                hit_4      = (paddr == `PCD_OFS_DIS4);
	wire                hit_5      = (paddr == `PCD_OFS_DIS5);
	wire                hit_any    = hit_1 | hit_2 | hit_3 | hit_4 | hit_5;
	wire                setup      = psel & ~penable & ce;
	wire                access     = psel & penable & ce;
	wire                wr_access  = access & pwrite & hit_any;
	wire [31:0]         lane_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// Write data merged per byte lane, unassigned bits forced low
	wire [31:0]         next_dis_1 = ((pwdata & lane_mask) | (periph_disable_1 & ~lane_mask))
	                                 & WMASK_1;
	wire [31:0]         next_dis_2 = ((pwdata & lane_mask) | (periph_disable_2 & ~lane_mask))
	                                 & WMASK_2;
	wire [31:0]         next_dis_3 = ((pwdata & lane_mask) | (periph_disable_3 & ~lane_mask))
	                                 & WMASK_3;
	wire [31:0]         next_dis_4 = ((pwdata & lane_mask) | (periph_disable_4 & ~lane_mask))
	                                 & WMASK_4;
	wire [31:0]         next_dis_5 = ((pwdata & lane_mask) | (periph_disable_5 & ~lane_mask))
	                                 & WMASK_5;

	// Read mux
	wire [31:0]         rd_sel     = ({32{hit_1}} & periph_disable_1)
	                               | ({32{hit_2}} & periph_disable_2)
	                               | ({32{hit_3}} & periph_disable_3)
	                               | ({32{hit_4}} & periph_disable_4)
	                               | ({32{hit_5}} & periph_disable_5);

	// No wait state while ce is high; read data and error come from flip-flops loaded in the setup cycle
	assign pready = access;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h00000000 : rd_sel;
			pslverr <= ~hit_any;
		end
	end

	// Disable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_disable_1 <= `PCD_RST_DIS;
			periph_disable_2 <= `PCD_RST_DIS;
			periph_disable_3 <= `PCD_RST_DIS;
			periph_disable_4 <= `PCD_RST_DIS;
			periph_disable_5 <= `PCD_RST_DIS;
		end else if (wr_access) begin
			if (hit_1) begin
				periph_disable_1 <= next_dis_1;
			end
			if (hit_2) begin
				periph_disable_2 <= next_dis_2;
			end
			if (hit_3) begin
				periph_disable_3 <= next_dis_3;
			end
			if (hit_4) begin
				periph_disable_4 <= next_dis_4;
			end
			if (hit_5) begin
				periph_disable_5 <= next_dis_5;
			end
		end
	end

	// Flat vector: adc, vref, comparators, captures, compares, timers, uarts
	assign periph_disable_bit = {
		periph_disable_5[`PCD_MSB_UART:`PCD_LSB_UART],
		periph_disable_4[`PCD_MSB_TIMER:`PCD_LSB_TIMER],
		periph_disable_3[`PCD_MSB_COMPARE:`PCD_LSB_COMPARE],
		periph_disable_3[`PCD_MSB_CAPTURE:`PCD_LSB_CAPTURE],
		periph_disable_2[`PCD_MSB_CMP:`PCD_LSB_CMP],
		periph_disable_1[`PCD_BIT_VREF],
		periph_disable_1[`PCD_BIT_ADC]
	};

	// Software must have switched the peripheral off first; the gate does not check
	// that, so gating a running peripheral leaves it frozen mid-operation
	genvar gi;
	generate
		for (gi = 0; gi < NPERIPH; gi++) begin : g_periph
			pcd_clk_gate u_gate (
				.clk    (pclk),
				.enable (~periph_disable_bit[gi]),
				.gclk   (periph_gclk[gi])
			);
			assign periph_pwrite_out[gi] = periph_pwrite_in[gi] & ~periph_disable_bit[gi];
			assign periph_rvalid[gi]     = ~periph_disable_bit[gi];

			// Latch must follow the flag before the next rising edge
			property p_gate_tracks;
				@(posedge pclk) disable iff (!presetn)
				u_gate.en_latched == ~periph_disable_bit[gi];
			endproperty
			a_gate_tracks: assert property (p_gate_tracks) else $error("gate latch lags");
		end
	endgenerate

	sequence s_write(logic hit);
		psel && penable && pwrite && ce && hit;
	endsequence

	sequence s_read_setup(logic hit);
		psel && !penable && !pwrite && ce && hit;
	endsequence

	property p_write_dis1;
		@(posedge pclk) disable iff (!presetn)
		s_write(hit_1 && (pstrb == 4'hF))
		|=> (periph_disable_1 == ($past(pwdata) & WMASK_1));
	endproperty
	a_write_dis1: assert property (p_write_dis1) else $error("disable 1 write lost");

	property p_write_dis3;
		@(posedge pclk) disable iff (!presetn)
		s_write(hit_3 && (pstrb == 4'hF))
		|=> (periph_disable_3 == ($past(pwdata) & WMASK_3));
	endproperty
	a_write_dis3: assert property (p_write_dis3) else $error("disable 3 write lost");

	property p_write_dis2;
		@(posedge pclk) disable iff (!presetn)
		s_write(hit_2 && (pstrb == 4'hF))
		|=> (periph_disable_2 == ($past(pwdata) & WMASK_2));
	endproperty
	a_write_dis2: assert property (p_write_dis2) else $error("disable 2 write lost");

	property p_write_dis4;
		@(posedge pclk) disable iff (!presetn)
		s_write(hit_4 && (pstrb == 4'hF))
		|=> (periph_disable_4 == ($past(pwdata) & WMASK_4));
	endproperty
	a_write_dis4: assert property (p_write_dis4) else $error("disable 4 write lost");

	property p_write_dis5;
		@(posedge pclk) disable iff (!presetn)
		s_write(hit_5 && (pstrb == 4'hF))
		|=> (periph_disable_5 == ($past(pwdata) & WMASK_5));
	endproperty
	a_write_dis5: assert property (p_write_dis5) else $error("disable 5 write lost");

	property p_lane_merge;
		@(posedge pclk) disable iff (!presetn)
		s_write(hit_4 && (pstrb != 4'hF))
		|=> (periph_disable_4 == ((($past(pwdata) & $past(lane_mask))
		    | ($past(periph_disable_4) & ~$past(lane_mask))) & WMASK_4));
	endproperty
	a_lane_merge: assert property (p_lane_merge) else $error("byte lane merge wrong");

	property p_unmapped_wr;
		@(posedge pclk) disable iff (!presetn)
		s_write(!hit_any)
		|=> $stable(periph_disable_1) && $stable(periph_disable_2)
		    && $stable(periph_disable_3) && $stable(periph_disable_4)
		    && $stable(periph_disable_5);
	endproperty
	a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write stored");

	property p_unassigned_zero;
		@(posedge pclk) disable iff (!presetn)
		((periph_disable_1 & ~`PCD_MASK_DIS1) == 32'h00000000)
		&& ((periph_disable_3 & ~`PCD_MASK_DIS3) == 32'h00000000)
		&& ((periph_disable_4 & ~`PCD_MASK_DIS4) == 32'h00000000);
	endproperty
	a_unassigned_zero: assert property (p_unassigned_zero) else $error("unassigned bit set");

	property p_absent_zero;
		@(posedge pclk) disable iff (!presetn)
		((periph_disable_2 & ~PRESENT_2) == 32'h00000000)
		&& ((periph_disable_5 & ~PRESENT_5) == 32'h00000000);
	endproperty
	a_absent_zero: assert property (p_absent_zero) else $error("absent peripheral flag set");

	property p_read_back;
		@(posedge pclk) disable iff (!presetn)
		s_read_setup(hit_4) ##1 (psel && penable) |-> (prdata == $past(periph_disable_4));
	endproperty
	a_read_back: assert property (p_read_back) else $error("disable 4 read wrong");

	property p_read_dis1;
		@(posedge pclk) disable iff (!presetn)
		s_read_setup(hit_1) ##1 (psel && penable) |-> (prdata == $past(periph_disable_1));
	endproperty
	a_read_dis1: assert property (p_read_dis1) else $error("disable 1 read wrong");

	property p_read_dis3;
		@(posedge pclk) disable iff (!presetn)
		s_read_setup(hit_3) ##1 (psel && penable) |-> (prdata == $past(periph_disable_3));
	endproperty
	a_read_dis3: assert property (p_read_dis3) else $error("disable 3 read wrong");

	property p_read_dis5;
		@(posedge pclk) disable iff (!presetn)
		s_read_setup(hit_5) ##1 (psel && penable) |-> (prdata == $past(periph_disable_5));
	endproperty
	a_read_dis5: assert property (p_read_dis5) else $error("disable 5 read wrong");

	property p_bit_map;
		@(posedge pclk) disable iff (!presetn)
		(periph_disable_bit[1] == periph_disable_1[12])
		&& (periph_disable_bit[13] == periph_disable_3[16])
		&& (periph_disable_bit[21] == periph_disable_3[24])
		&& (periph_disable_bit[32] == periph_disable_5[1]);
	endproperty
	a_bit_map: assert property (p_bit_map) else $error("disable bit misplaced");

	property p_write_blocked;
		@(posedge pclk) disable iff (!presetn)
		(periph_pwrite_out == (periph_pwrite_in & ~periph_disable_bit))
		&& (periph_rvalid == ~periph_disable_bit);
	endproperty
	a_write_blocked: assert property (p_write_blocked) else $error("disabled peripheral accessed");

	property p_gate_follows;
		@(posedge pclk) disable iff (!presetn)
		$rose(periph_disable_bit[0]) |-> ##1 (g_periph[0].u_gate.en_latched == 1'b0);
	endproperty
	a_gate_follows: assert property (p_gate_follows) else $error("adc clock not stopped");

	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		!ce |=> $stable(periph_disable_1) && $stable(periph_disable_2)
		        && $stable(periph_disable_3) && $stable(periph_disable_4)
		        && $stable(periph_disable_5) && $stable(prdata);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

	property p_unmapped_err;
		@(posedge pclk) disable iff (!presetn)
		setup && !hit_any ##1 access |-> pslverr && pready;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not flagged");

	property p_write_rdata_zero;
		@(posedge pclk) disable iff (!presetn)
		setup && pwrite |=> (prdata == 32'h00000000);
	endproperty
	a_write_rdata_zero: assert property (p_write_rdata_zero) else $error("write returned data");

	property p_mapped_ok;
		@(posedge pclk) disable iff (!presetn)
		setup && hit_any |=> !pslverr;
	endproperty
	a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged");
endmodule // pcd_top

// *** hdl/pcd_params.svh ***
// Offsets, field layouts and reset values of the peripheral clock disable block
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH

// Register byte offsets
`define PCD_OFS_DIS1 12'h000
`define PCD_OFS_DIS2 12'h004
`define PCD_OFS_DIS3 12'h008
`define PCD_OFS_DIS4 12'h00C
`define PCD_OFS_DIS5 12'h010

// Bits that carry a disable flag in each register
`define PCD_MASK_DIS1 32'h00001001
`define PCD_MASK_DIS2 32'h00000003
`define PCD_MASK_DIS3 32'h01FF01FF
`define PCD_MASK_DIS4 32'h000001FF
`define PCD_MASK_DIS5 32'h00000003

// Field positions
`define PCD_BIT_ADC      0
`define PCD_BIT_VREF     12
`define PCD_LSB_CMP      0
`define PCD_MSB_CMP      1
`define PCD_LSB_CAPTURE  0
`define PCD_MSB_CAPTURE  8
`define PCD_LSB_COMPARE  16
`define PCD_MSB_COMPARE  24
`define PCD_LSB_TIMER    0
`define PCD_MSB_TIMER    8
`define PCD_LSB_UART     0
`define PCD_MSB_UART     1

// Reset value of every disable register
`define PCD_RST_DIS 32'h00000000

// Count of gated peripherals
`define PCD_NUM_PERIPH 33

`endif

// *** hdl/pcd_pkg.sv ***
// Types shared by the peripheral clock disable block
package pcd_pkg;
	typedef logic [31:0] pcd_word_t;
	typedef logic [11:0] pcd_addr_t;
endpackage

// *** hdl/pcd_clk_gate.sv ***
// Glitch-free clock gate for one peripheral
`timescale 1ns/1ps
module pcd_clk_gate (
	// Clock in
	input  wire logic clk,
	// Gate control
	input  wire logic enable,
	// Clock out
	output logic      gclk
);
	logic en_latched;

	// Enable is only taken while the clock is low, so the output never gets a runt pulse
	always_latch begin
		if (!clk) begin
			en_latched = enable;
		end
	end

	assign gclk = clk & en_latched;
endmodule // pcd_clk_gate

// *** verification/pcd_top_bench.sv ***
// Register-level bench of the peripheral clock disable block
`timescale 1ns/1ps
`include "pcd_params.svh"
module pcd_top_bench;
	// Compare9 left out to model a variant with an absent peripheral
	localparam logic [31:0] P3 = 32'h00FF01FF;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               ce = 1'b1;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	pcd_pkg::pcd_addr_t paddr = 12'h000;
	pcd_pkg::pcd_word_t pwdata = 32'h00000000;
	logic [3:0]         pstrb = 4'hF;
	logic               pready;
	pcd_pkg::pcd_word_t prdata;
	logic               pslverr;
	logic [32:0]        flags;
	logic [32:0]        gclk;
	logic [32:0]        wr_in = 33'h155555555;
	logic [32:0]        wr_out;
	logic [32:0]        rvalid;
	int                 fails = 0;
	int                 n_checks = 0;
	pcd_pkg::pcd_addr_t ofs [5] = '{`PCD_OFS_DIS1, `PCD_OFS_DIS2, `PCD_OFS_DIS3,
		`PCD_OFS_DIS4, `PCD_OFS_DIS5};
	pcd_pkg::pcd_word_t msk [5] = '{`PCD_MASK_DIS1, `PCD_MASK_DIS2, P3,
		`PCD_MASK_DIS4, `PCD_MASK_DIS5};
	// Flags expected once registers 1..i+1 have been written with all ones
	logic [32:0]        fl [5] = '{33'h000000003, 33'h00000000F, 33'h0001FFFFF,
		33'h07FDFFFFF, 33'h1FFDFFFFF};

	always #4 pclk = ~pclk;

	pcd_top #(.PRESENT_3(P3)) dut_u (
		.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .periph_disable_bit(flags), .periph_gclk(gclk),
		.periph_pwrite_in(wr_in), .periph_pwrite_out(wr_out), .periph_rvalid(rvalid)
	);

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held from setup until pready is seen high at a rising edge
	task automatic apb(input logic w, input pcd_pkg::pcd_addr_t a,
		input pcd_pkg::pcd_word_t d, input logic [3:0] s,
		output pcd_pkg::pcd_word_t r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input pcd_pkg::pcd_addr_t a, input pcd_pkg::pcd_word_t d,
		input logic [3:0] s);
		pcd_pkg::pcd_word_t r;
		logic e;
		apb(1'b1, a, d, s, r, e);
	endtask

	task automatic rd(input pcd_pkg::pcd_addr_t a, input pcd_pkg::pcd_word_t exp,
		input logic experr);
		pcd_pkg::pcd_word_t r;
		logic e;
		apb(1'b0, a, 32'h00000000, 4'hF, r, e);
		chk(r, exp);
		chk(e, experr);
	endtask

	// Gated peripherals lose clock, writes and read validity together
	task automatic check_gate(input logic [32:0] f);
		logic [32:0] nf;
		logic [32:0] wo;
		@(negedge pclk);
		nf = ~f;
		wo = wr_in & nf;
		chk(flags, f);
		chk(wr_out, wo);
		chk(rvalid, nf);
		@(posedge pclk);
		#1;
		chk(gclk, nf);
	endtask

	// Drops the clock enable for three cycles once the setup cycle has been taken
	task automatic stall;
		repeat (2) @(posedge pclk);
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		tally_and_finish();
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		check_gate(33'h000000000);
		for (int i = 0; i < 5; i++) rd(ofs[i], `PCD_RST_DIS, 1'b0);
		// Peripherals here are idle and switched off, so gating them is always legal
		for (int i = 0; i < 5; i++) begin
			wr(ofs[i], 32'hFFFFFFFF, 4'hF);
			check_gate(fl[i]);
			rd(ofs[i], msk[i], 1'b0);
		end
		wr(12'h014, 32'hFFFFFFFF, 4'hF);
		rd(12'h014, 32'h00000000, 1'b1);
		// Lane 1 only: clears timer9 and leaves timers 1-8 set
		wr(ofs[3], 32'h00000000, 4'h2);
		rd(ofs[3], 32'h000000FF, 1'b0);
		check_gate(33'h1BFDFFFFF);
		// Clock enable low in the access phase: the transfer waits, then completes
		fork
			wr(ofs[0], 32'h00001000, 4'hF);
			stall();
		join
		check_gate(33'h1BFDFFFFE);
		fork
			rd(ofs[0], 32'h00001000, 1'b0);
			stall();
		join
		// Complementary write strobes so every filter bit is seen both ways
		@(posedge pclk);
		wr_in <= 33'h0AAAAAAAA;
		check_gate(33'h1BFDFFFFE);
		// A reset in mid-run clears every flag at once
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check_gate(33'h000000000);
		for (int i = 0; i < 5; i++) rd(ofs[i], 32'h00000000, 1'b0);
		for (int i = 0; i < 5; i++) wr(ofs[i], 32'h00000000, 4'hF);
		check_gate(33'h000000000);
		tally_and_finish();
	end
endmodule // pcd_top_bench
